// *** aaf_pkg.sv ***
package aaf_pkg;

  // Register bus geometry
  localparam int          AXI_ADDR_W     = 4;             // Byte address bits decoded
  localparam int          AXI_DATA_W     = 32;            // Register data width
  localparam logic [1:0]  RESP_OKAY      = 2'h0;          // Normal completion
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;          // Unmapped address, or a write to status

  // Register byte offsets
  localparam logic [3:0]  REG_CTRL       = 4'h0;          // Local method select
  localparam logic [3:0]  REG_THRESH     = 4'h4;          // Fill thresholds
  localparam logic [3:0]  REG_CHARS      = 4'h8;          // Resume and pause codes
  localparam logic [3:0]  REG_STATUS     = 4'hC;          // Live state, read only

  // Field positions
  localparam int          CTRL_METHOD    = 0;             // 0 circuit pair, 1 in-band
  localparam int          TH_W           = 4;             // Threshold field width
  localparam int          TH_UP_LSB      = 0;             // upper_fill_threshold
  localparam int          TH_LO_LSB      = 8;             // lower_fill_threshold
  localparam int          CHR_W          = 7;             // Seven-bit character codes
  localparam int          CHR_RES_LSB    = 0;             // Resume code
  localparam int          CHR_PAU_LSB    = 8;             // Pause code
  localparam int          ST_CNT_LSB     = 0;             // Buffer fill count
  localparam int          ST_TXOFF       = 8;             // Our outgoing flow bit is OFF
  localparam int          ST_FAROFF      = 9;             // Far end asked us to stop
  localparam int          ST_HOLD        = 10;            // Outbound holding slot full
  localparam int          ST_STOP        = 11;            // Terminal is being stopped

  // Reset values
  localparam logic [TH_W-1:0]  UPPER_RST = 4'h6;          // Above this, flow bit OFF
  localparam logic [TH_W-1:0]  LOWER_RST = 4'h2;          // Below this, flow bit ON
  localparam logic [CHR_W-1:0] RESUME_RST = 7'h11;        // Table position 1/1
  localparam logic [CHR_W-1:0] PAUSE_RST  = 7'h13;        // Table position 1/3

  // Frame status bit coding
  localparam logic        FLOW_ON        = 1'b0;          // ON travels as zero
  localparam logic        FLOW_OFF       = 1'b1;          // OFF travels as one
  localparam logic [7:0]  IDLE_FILL      = 8'hFF;         // Data bits of an empty slot

  // Local flow control method
  typedef enum logic {
    AAF_CIRCUIT = 1'b0,
    AAF_INBAND  = 1'b1
  } aaf_method_e;

  // In-band signalling state
  typedef enum logic [1:0] {
    IB_RUN        = 2'b00,
    IB_SEND_PAUSE = 2'b01,
    IB_PAUSED     = 2'b10,
    IB_SEND_RES   = 2'b11
  } aaf_ib_state_e;

endpackage : aaf_pkg

// *** aaf_flow_ctrl.sv ***

// Line-side character buffer
module aaf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int CNT_W = $clog2(DEPTH + 1)
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [CNT_W-1:0]      count
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];   // Storage
  logic [PTR_W-1:0] wr_ptr_reg;        // Next write slot
  logic [PTR_W-1:0] rd_ptr_reg;        // Oldest entry
  logic [CNT_W-1:0] cnt_reg;           // Entries held
  logic             push;              // Write this cycle
  logic             pop;               // Read this cycle

  // Full and empty come straight from the count
  assign in_ready  = (cnt_reg != CNT_W'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign count     = cnt_reg;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer advance wraps at DEPTH, which need not be a power of two
  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : ptr_inc

  // Data store, no reset needed
  always_ff @(posedge aclk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule : aaf_fifo

// Flow control core with register slave
module aaf_flow_ctrl #(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // AXI4-Lite slave
  input  wire logic [aaf_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [aaf_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [aaf_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [aaf_pkg::AXI_DATA_W-1:0]     s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // Local terminal
  input  wire logic                          term_rts,
  output logic                               term_cts,
  input  wire logic                          term_rx_valid,
  output logic                               term_rx_ready,
  input  wire logic [7:0]                    term_rx_data,
  output logic                               term_tx_valid,
  input  wire logic                          term_tx_ready,
  output logic [7:0]                         term_tx_data,
  // Line receive side
  input  wire logic                          line_rx_valid,
  output logic                               line_rx_ready,
  input  wire logic [7:0]                    line_rx_data,
  input  wire logic                          line_rx_frame,
  input  wire logic                          line_rx_flow_bit,
  // Line transmit side
  input  wire logic                          line_tx_frame,
  output logic [7:0]                         line_tx_data,
  output logic                               line_tx_char_valid,
  output logic                               line_tx_flow_bit
);
  import aaf_pkg::*;

  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);

  aaf_method_e      method_reg;        // Selected local method
  logic [TH_W-1:0]  upper_reg;         // upper_fill_threshold
  logic [TH_W-1:0]  lower_reg;         // lower_fill_threshold
  logic [CHR_W-1:0] resume_reg;        // Resume character code
  logic [CHR_W-1:0] pause_reg;         // Pause character code
  logic             tx_off_reg;        // Our outgoing flow bit is OFF
  logic             far_off_reg;       // Last far flow bit seen was OFF
  logic [7:0]       hold_reg;          // Character waiting for a frame slot
  logic             hold_full_reg;     // Holding slot occupied
  logic             hold_early_reg;    // Captured before the far end stopped us
  aaf_ib_state_e    ib_reg;            // In-band signalling state
  aaf_ib_state_e    ib_next;           // Its next value
  logic [CNT_W-1:0] fill_cnt;          // Buffer fill level
  logic             fifo_out_valid;    // Buffer has a character
  logic [7:0]       fifo_out_data;     // Oldest buffered character
  logic             fifo_pop;          // Terminal takes a buffered character
  logic             stop_req;          // Terminal must stop sending
  logic             inject;            // In-band code owns the terminal path
  logic             send_hold;         // Slot carries the held character
  logic             aw_got_reg;        // Write address captured
  logic             w_got_reg;         // Write data captured
  logic [AXI_ADDR_W-1:0] awaddr_reg;   // Captured write address
  logic [AXI_DATA_W-1:0] wdata_reg;    // Captured write data
  logic [3:0]       wstrb_reg;         // Captured byte enables
  logic             wr_fire;           // Both halves of a write present

  // Line characters are buffered; arrivals after throttling still land here
  aaf_fifo #(
    .WIDTH    (8),
    .DEPTH    (FIFO_DEPTH),
    .CNT_W    (CNT_W)
  ) u_line_buf (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (line_rx_valid),
    .in_ready  (line_rx_ready),
    .in_data   (line_rx_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data),
    .count     (fill_cnt)
  );

  // A full holding slot means the terminal outruns the line: throttle it
  assign stop_req = far_off_reg || hold_full_reg;

  // Circuit pair: grant only on request and only while nothing stops us
  assign term_cts = (method_reg == AAF_CIRCUIT) && term_rts && !stop_req;

  // A character the terminal already started is always taken if there is room
  assign term_rx_ready = !hold_full_reg;

  // In-band codes pre-empt buffered data toward the terminal
  assign inject        = (ib_reg == IB_SEND_PAUSE) || (ib_reg == IB_SEND_RES);
  assign term_tx_valid = inject || fifo_out_valid;
  assign term_tx_data  = (ib_reg == IB_SEND_PAUSE) ? {1'b0, pause_reg} :
                         (ib_reg == IB_SEND_RES)   ? {1'b0, resume_reg} : fifo_out_data;
  assign fifo_pop      = !inject && term_tx_ready;

  // In-band next state; only this method may use the state machine
  always_comb begin
    ib_next = ib_reg;
    if (method_reg != AAF_INBAND) begin
      ib_next = IB_RUN;
    end else begin
      case (ib_reg)
        IB_RUN: begin
          if (stop_req) begin
            ib_next = IB_SEND_PAUSE;
          end
        end
        IB_SEND_PAUSE: begin
          if (term_tx_ready) begin
            ib_next = IB_PAUSED;
          end
        end
        IB_PAUSED: begin
          if (!stop_req) begin
            ib_next = IB_SEND_RES;
          end
        end
        IB_SEND_RES: begin
          if (term_tx_ready) begin
            ib_next = IB_RUN;
          end
        end
        default: begin
          ib_next = IB_RUN;
        end
      endcase
    end
  end

  // In-band state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ib_reg <= IB_RUN;
    end else begin
      ib_reg <= ib_next;
    end
  end

  // Far-end flow bit, sampled once per received frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      far_off_reg <= 1'b0;
    end else if (line_rx_frame) begin
      far_off_reg <= (line_rx_flow_bit == FLOW_OFF);
    end
  end

  // Outgoing flow bit with hysteresis between the two thresholds
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_off_reg <= 1'b0;
    end else if (!tx_off_reg && (fill_cnt > CNT_W'(upper_reg))) begin
      tx_off_reg <= 1'b1;
    end else if (tx_off_reg && (fill_cnt < CNT_W'(lower_reg))) begin
      tx_off_reg <= 1'b0;
    end
  end

  // Held character leaves unless the far end had already stopped us when it arrived and still does
  assign send_hold = hold_full_reg && (!far_off_reg || hold_early_reg);

  // Holding slot between terminal and line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_reg       <= 8'h00;
      hold_full_reg  <= 1'b0;
      hold_early_reg <= 1'b0;
    end else if (term_rx_valid && !hold_full_reg) begin
      hold_reg       <= term_rx_data;
      hold_full_reg  <= 1'b1;
      hold_early_reg <= !far_off_reg;
    end else if (line_tx_frame && send_hold) begin
      hold_full_reg  <= 1'b0;
    end
  end

  // One character slot per outgoing frame; empty slots carry all ones
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_tx_data       <= IDLE_FILL;
      line_tx_char_valid <= 1'b0;
      line_tx_flow_bit   <= FLOW_ON;
    end else if (line_tx_frame) begin
      line_tx_data       <= send_hold ? hold_reg : IDLE_FILL;
      line_tx_char_valid <= send_hold;
      line_tx_flow_bit   <= tx_off_reg ? FLOW_OFF : FLOW_ON;
    end
  end

  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_reg && !s_axi_bvalid;
  assign wr_fire       = aw_got_reg && w_got_reg && !s_axi_bvalid;

  // Capture write halves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg  <= '0;
      wstrb_reg  <= 4'h0;
    end else if (wr_fire) begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
    end
  end

  // Write response; status and unmapped words answer an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_reg == REG_CTRL || awaddr_reg == REG_THRESH ||
                       awaddr_reg == REG_CHARS) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration registers, written byte lane by byte lane
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      method_reg <= AAF_CIRCUIT;
      upper_reg  <= UPPER_RST;
      lower_reg  <= LOWER_RST;
      resume_reg <= RESUME_RST;
      pause_reg  <= PAUSE_RST;
    end else if (wr_fire) begin
      case (awaddr_reg)
        REG_CTRL: begin
          if (wstrb_reg[0]) begin
            method_reg <= aaf_method_e'(wdata_reg[CTRL_METHOD]);
          end
        end
        REG_THRESH: begin
          // Software must keep lower above zero or the bit never clears
          if (wstrb_reg[0]) begin
            upper_reg <= wdata_reg[TH_UP_LSB +: TH_W];
          end
          if (wstrb_reg[1]) begin
            lower_reg <= wdata_reg[TH_LO_LSB +: TH_W];
          end
        end
        REG_CHARS: begin
          if (wstrb_reg[0]) begin
            resume_reg <= wdata_reg[CHR_RES_LSB +: CHR_W];
          end
          if (wstrb_reg[1]) begin
            pause_reg <= wdata_reg[CHR_PAU_LSB +: CHR_W];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Read channel: one read at a time, answered the cycle after acceptance
  assign s_axi_arready = !s_axi_rvalid;

  // Read data and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL: begin
          s_axi_rdata[CTRL_METHOD] <= method_reg;
        end
        REG_THRESH: begin
          s_axi_rdata[TH_UP_LSB +: TH_W] <= upper_reg;
          s_axi_rdata[TH_LO_LSB +: TH_W] <= lower_reg;
        end
        REG_CHARS: begin
          s_axi_rdata[CHR_RES_LSB +: CHR_W] <= resume_reg;
          s_axi_rdata[CHR_PAU_LSB +: CHR_W] <= pause_reg;
        end
        REG_STATUS: begin
          s_axi_rdata[ST_CNT_LSB +: CNT_W] <= fill_cnt;
          s_axi_rdata[ST_TXOFF]            <= tx_off_reg;
          s_axi_rdata[ST_FAROFF]           <= far_off_reg;
          s_axi_rdata[ST_HOLD]             <= hold_full_reg;
          s_axi_rdata[ST_STOP]             <= stop_req;
        end
        default: begin
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : aaf_flow_ctrl

// *** aaf_flow_ctrl_properties.sv ***
// Port-level checker for the flow control core
module aaf_chk (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       term_rts,
  input wire logic       term_cts,
  input wire logic       line_rx_frame,
  input wire logic       line_rx_flow_bit,
  input wire logic       line_tx_frame,
  input wire logic [7:0] line_tx_data,
  input wire logic       line_tx_char_valid,
  input wire logic       line_tx_flow_bit
);
  timeunit 1ns;
  timeprecision 1ns;
  // One clock domain, so one default for all properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Grant only ever answers a standing request
  property p_cts_rts; term_cts |-> term_rts; endproperty
  a_cts_rts: assert property (p_cts_rts) else $error("cts without rts");
  // A far OFF frame stops the terminal on the next cycle
  property p_far_off; line_rx_frame && line_rx_flow_bit |=> !term_cts; endproperty
  a_far_off: assert property (p_far_off) else $error("cts after far OFF");
  // An empty outgoing slot carries all ones
  property p_fill_ones; line_tx_frame |=> line_tx_char_valid || line_tx_data == 8'hFF; endproperty
  a_fill_ones: assert property (p_fill_ones) else $error("empty slot not ones");
  // Slot contents change only at a frame slot
  property p_slot_hold; !line_tx_frame |=> $stable(line_tx_flow_bit) && $stable(line_tx_data); endproperty
  a_slot_hold: assert property (p_slot_hold) else $error("slot changed mid frame");
  // No new write taken while a response waits
  property p_b_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_b_refuse: assert property (p_b_refuse) else $error("write taken during response");
  // A response is given once
  property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_once: assert property (p_b_once) else $error("response repeated");
  // Read answered one cycle after it is taken
  property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_answer: assert property (p_r_answer) else $error("read not answered");
  // No new read taken while data waits
  property p_r_refuse; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_r_refuse: assert property (p_r_refuse) else $error("read taken during data");
endmodule : aaf_chk

bind aaf_flow_ctrl aaf_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .term_rts(term_rts), .term_cts(term_cts),
  .line_rx_frame(line_rx_frame), .line_rx_flow_bit(line_rx_flow_bit), .line_tx_frame(line_tx_frame),
  .line_tx_data(line_tx_data), .line_tx_char_valid(line_tx_char_valid), .line_tx_flow_bit(line_tx_flow_bit)
);

// *** aaf_far_end.sv ***
// Far adapter: frame slots, flow bit and a line character stream
module aaf_far_end (
  input wire logic  aclk,
  input wire logic  aresetn,
  input wire logic  push_en,
  input wire logic  far_off,
  input wire logic  line_rx_ready,
  output logic       line_rx_valid,
  output logic [7:0] line_rx_data,
  output logic       line_rx_frame,
  output logic       line_rx_flow_bit,
  output logic       line_tx_frame
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cyc_reg;  // Frame timing
  logic [7:0] chr_reg;  // Next character, counts up from zero

  // Outgoing slot every 4 cycles, incoming frame every 8
  always_ff @(posedge aclk) begin
    cyc_reg          <= aresetn ? cyc_reg + 3'h1 : 3'h0;
    line_tx_frame    <= aresetn && cyc_reg[1:0] == 2'h0;
    line_rx_frame    <= aresetn && cyc_reg == 3'h4;
    // Flow bit valid only with a frame; it wanders in between
    line_rx_flow_bit <= (cyc_reg == 3'h4) ? far_off : ~line_rx_flow_bit;
  end

  // Valid held until taken, so no character is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_rx_valid <= 1'h0;
      chr_reg       <= 8'h00;
    end else if (line_rx_valid && line_rx_ready) begin
      line_rx_valid <= push_en;
      chr_reg       <= chr_reg + 8'h01;
    end else if (!line_rx_valid) begin
      line_rx_valid <= push_en;
    end
  end

  // Idle data shows the inverse, never a stale copy
  assign line_rx_data = line_rx_valid ? chr_reg : ~chr_reg;
endmodule : aaf_far_end

// *** tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import aaf_pkg::*;

  typedef struct packed {logic wr; logic [3:0] a; logic [31:0] d; logic [1:0] r;} aaf_row_s;
  // Register rows: reads give expected data, writes give data to store
  localparam aaf_row_s ROWS [11] = '{
    '{1'h0, REG_CTRL, 32'h0, RESP_OKAY}, '{1'h0, REG_THRESH, 32'h206, RESP_OKAY},
    '{1'h0, REG_CHARS, 32'h1311, RESP_OKAY}, '{1'h0, REG_STATUS, 32'h0, RESP_OKAY},
    '{1'h1, REG_CHARS, 32'h2A55, RESP_OKAY}, '{1'h0, REG_CHARS, 32'h2A55, RESP_OKAY},
    '{1'h1, REG_CHARS, 32'h1311, RESP_OKAY}, '{1'h1, REG_THRESH, 32'h105, RESP_OKAY},
    '{1'h0, REG_THRESH, 32'h105, RESP_OKAY}, '{1'h1, REG_STATUS, 32'hF, RESP_SLVERR},
    '{1'h0, REG_STATUS, 32'h0, RESP_OKAY}};

  logic aclk = 1'h0, aresetn = 1'h0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0]  bresp, rresp, rsp;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic term_rts = 1'h0, term_rx_valid = 1'h0, term_tx_ready = 1'h0;
  logic [7:0] term_rx_data = 8'h00, term_tx_data, lrx_data, ltx_data;
  logic term_cts, term_rx_ready, term_tx_valid;
  logic lrx_valid, lrx_ready, lrx_frame, lrx_flow, ltx_frame, ltx_cv, ltx_flow;
  logic push_en = 1'h0, far_off = 1'h0, chk_seq = 1'h0;  // Far side commands and the order check enable
  logic [7:0] exp_rx = 8'h00;                             // Next line character due
  int n_fail = 0, compares = 0, k;

  aaf_flow_ctrl #(.FIFO_DEPTH(8)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .term_rts(term_rts), .term_cts(term_cts),
    .term_rx_valid(term_rx_valid), .term_rx_ready(term_rx_ready), .term_rx_data(term_rx_data),
    .term_tx_valid(term_tx_valid), .term_tx_ready(term_tx_ready), .term_tx_data(term_tx_data),
    .line_rx_valid(lrx_valid), .line_rx_ready(lrx_ready), .line_rx_data(lrx_data), .line_rx_frame(lrx_frame),
    .line_rx_flow_bit(lrx_flow), .line_tx_frame(ltx_frame), .line_tx_data(ltx_data),
    .line_tx_char_valid(ltx_cv), .line_tx_flow_bit(ltx_flow));

  aaf_far_end u_far (
    .aclk(aclk), .aresetn(aresetn), .push_en(push_en), .far_off(far_off), .line_rx_ready(lrx_ready),
    .line_rx_valid(lrx_valid), .line_rx_data(lrx_data), .line_rx_frame(lrx_frame),
    .line_rx_flow_bit(lrx_flow), .line_tx_frame(ltx_frame));

  // 25 MHz clock
  initial begin
    forever #20 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Write: both halves offered together, each dropped once taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 1'h1;
    w = 1'h1;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && awready) begin aw = 1'h0; awvalid <= 1'h0; end
      if (w && wready) begin w = 1'h0; wvalid <= 1'h0; end
    end
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'h0;
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask : axi_rd

  task automatic final_report;
    if (n_fail == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  // Line characters must reach the terminal in arrival order
  always @(negedge aclk) begin
    if (chk_seq && term_tx_valid && term_tx_ready) begin
      chk({24'h0, term_tx_data}, {24'h0, exp_rx});
      exp_rx <= exp_rx + 8'h01;
    end
  end

  // Watchdog, well beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge aclk);
    n_fail++;
    final_report();
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(negedge aclk);
    chk({ltx_data, ltx_cv, ltx_flow, term_cts, lrx_ready}, {8'hFF, 4'h1});
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) axi_wr(ROWS[i].a, ROWS[i].d, rsp);
      else axi_rd(ROWS[i].a, rd, rsp);
      if (!ROWS[i].wr) chk(rd, ROWS[i].d);
      chk({30'h0, rsp}, {30'h0, ROWS[i].r});
    end
    // Circuit pair: grant follows request, far OFF withdraws it
    @(posedge aclk); term_rts <= 1'h1;
    repeat (3) @(negedge aclk);
    chk({31'h0, term_cts}, 32'h1);
    @(posedge aclk); far_off <= 1'h1;
    repeat (10) @(negedge aclk);
    chk({31'h0, term_cts}, 32'h0);
    @(posedge aclk); far_off <= 1'h0;
    repeat (10) @(negedge aclk);
    chk({31'h0, term_cts}, 32'h1);
    // Terminal character goes out in the next slot, marked as a valid character
    @(posedge aclk); term_rx_data <= 8'hA5; term_rx_valid <= 1'h1;
    do @(posedge aclk); while (!term_rx_ready);
    term_rx_valid <= 1'h0; term_rx_data <= 8'h5A;
    for (k = 0; k < 20 && !ltx_cv; k++) @(negedge aclk);
    chk({23'h0, ltx_cv, ltx_data}, 32'h1A5);
    // Fill line buffer with terminal stalled until refused
    @(posedge aclk); push_en <= 1'h1;
    for (k = 0; k < 50 && lrx_ready !== 1'h0; k++) @(negedge aclk);
    @(posedge aclk); push_en <= 1'h0;
    axi_rd(REG_STATUS, rd, rsp);
    chk(rd, 32'h108);
    repeat (6) @(negedge aclk);
    chk({31'h0, ltx_flow}, {31'h0, FLOW_OFF});
    // Drain in order, then flow bit returns ON
    @(posedge aclk); chk_seq <= 1'h1; term_tx_ready <= 1'h1;
    for (k = 0; k < 50 && term_tx_valid !== 1'h0; k++) @(negedge aclk);
    // The far side still holds one character when the buffer refuses it, so nine arrive
    chk({24'h0, exp_rx}, 32'h9);
    repeat (6) @(negedge aclk);
    chk({31'h0, ltx_flow}, {31'h0, FLOW_ON});
    // In-band: no grant, pause then resume codes offered
    @(posedge aclk); chk_seq <= 1'h0;
    axi_wr(REG_CTRL, 32'h1, rsp);
    @(negedge aclk);
    chk({31'h0, term_cts}, 32'h0);
    @(posedge aclk); far_off <= 1'h1;
    for (k = 0; k < 30 && !term_tx_valid; k++) @(negedge aclk);
    chk({24'h0, term_tx_data}, {25'h0, PAUSE_RST});
    // Terminal stays silent from the pause code until the resume code
    @(posedge aclk); far_off <= 1'h0;
    @(negedge aclk);
    for (k = 0; k < 30 && !term_tx_valid; k++) @(negedge aclk);
    chk({24'h0, term_tx_data}, {25'h0, RESUME_RST});
    // Only after the resume code does the terminal send again
    @(posedge aclk); term_rx_data <= 8'h3C; term_rx_valid <= 1'h1;
    do @(posedge aclk); while (!term_rx_ready);
    term_rx_valid <= 1'h0;
    for (k = 0; k < 20 && !ltx_cv; k++) @(negedge aclk);
    chk({23'h0, ltx_cv, ltx_data}, 32'h13C);
    final_report();
  end
endmodule : tb_top
